/* dv/lalc_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module lalc_checker (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic all_ones_alarm_i,
	input wire logic rx_signal_lost_i,
	input wire logic test_pattern_locked_i,
	input wire logic remote_loopback_o,
	input wire logic irq_o
);
	logic [3:0] en_q;
	logic rd_st;
	assign rd_st = psel_i && !penable_i && !pwrite_i && paddr_i == lalc_pkg::OFS_STATUS;
	// Enable mirror, so irq can be judged
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			en_q <= 4'h0;
		else if (psel_i && penable_i && pwrite_i && paddr_i == lalc_pkg::OFS_IRQ_EN)
			en_q <= pwdata_i[3:0];
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	ones_live_a: assert property ($stable(all_ones_alarm_i)[*6] ##0 rd_st
		|=> prdata_o[2] == $past(all_ones_alarm_i)) else $error("ones bit");
	lost_live_a: assert property ($stable(rx_signal_lost_i)[*6] ##0 rd_st
		|=> prdata_o[1] == $past(rx_signal_lost_i)) else $error("lost bit");
	lock_live_a: assert property ($stable(test_pattern_locked_i)[*6] ##0 rd_st
		|=> prdata_o[0] == $past(test_pattern_locked_i)) else $error("lock bit");
	loop_hold_a: assert property (rd_st && remote_loopback_o |=> prdata_o[3]) else $error("loop bit");
	loop_drop_a: assert property (en_q[3] && $fell(remote_loopback_o)
		|-> ##[0:4] irq_o) else $error("loop irq");
	irq_mask_a: assert property (irq_o |-> en_q != 4'h0) else $error("masked irq");
	ones_irq_a: assert property (en_q[2] && $changed(all_ones_alarm_i) |-> ##[3:7] irq_o) else $error("ones irq");
	lost_irq_a: assert property (en_q[1] && $changed(rx_signal_lost_i) |-> ##[3:7] irq_o) else $error("lost irq");
	lock_irq_a: assert property (en_q[0] && $changed(test_pattern_locked_i) |-> ##[3:7] irq_o) else $error("lock irq");
	cover property (rd_st && remote_loopback_o);
	cover property ($rose(remote_loopback_o));
	cover property ($fell(remote_loopback_o));
endmodule // lalc_checker
`default_nettype wire

/* dv/lalc_line_gen.sv */
`timescale 1ns/10ps
`default_nettype none
// Far end: code 0 sends ones, 1 loop-up, 2 loop-down
module lalc_line_gen #(
	parameter int DIV = 4
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic [1:0] code_i,
	output logic tog_o = 1'b0,
	output logic dat_o = 1'b1
);
	int cnt;
	int pos;
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= 0;
			pos <= 0;
			tog_o <= 1'b0;
			dat_o <= 1'b1;
		end else begin
			cnt <= (cnt + 1) % DIV;
			// Data moves half a bit ahead of the toggle
			if (cnt == 0) begin
				pos <= (pos + 1) % 15;
				dat_o <= code_i == 2'h1 ? pos % 5 == 4 : code_i == 2'h2 ? pos % 3 == 2 : 1'b1;
			end
			if (cnt == DIV / 2)
				tog_o <= ~tog_o;
		end
	end
endmodule // lalc_line_gen
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [11:0] padr = 12'h000;
	logic [31:0] pwd = 32'h0;
	logic [31:0] prd;
	logic rdy, err, tog, dat, lb, irq;
	logic ones = 1'b0;
	logic lost = 1'b0;
	logic lock = 1'b0;
	logic [1:0] code = 2'h0;
	logic [3:0] xst = 4'h0;
	logic [3:0] xflag = 4'h0;
	logic [3:0] xen = 4'h0;
	logic xauto = 1'b0;
	logic [31:0] s;
	int seed = 32'h3FBD;
	int bad_count = 0;
	int cmp_count = 0;
	always #4 mclk_i = ~mclk_i;
	// Short hold count keeps the run brief
	lalc_top #(.HOLD_COUNT(40'hC8)) DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err),
		.rx_bit_valid_i(tog), .rx_data_i(dat), .all_ones_alarm_i(ones), .rx_signal_lost_i(lost),
		.test_pattern_locked_i(lock), .remote_loopback_o(lb), .irq_o(irq));
	lalc_line_gen #(.DIV(4)) far (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .code_i(code), .tog_o(tog), .dat_o(dat));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge mclk_i);
		pen <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do begin
			@(posedge mclk_i);
		end while (rdy !== 1'b1);
		chk(32'(err), 32'h0);
		if (!w)
			chk(prd, d);
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic rdflag();
		bus(1'b0, lalc_pkg::OFS_IRQ_FLAG, {28'h0, xflag});
		xflag = 4'h0;
	endtask
	task automatic settle(input logic [1:0] c, input logic [3:0] v, input int n);
		@(posedge mclk_i);
		code <= c;
		ones <= v[2];
		lost <= v[1];
		lock <= v[0];
		xflag = xflag | (v ^ xst);
		xst = v;
		repeat (n) @(posedge mclk_i);
		bus(1'b0, lalc_pkg::OFS_STATUS, {28'h0, xst});
		chk(32'(irq), 32'(|(xflag & xen)));
		chk(32'(lb), 32'(xst[3] && xauto));
	endtask
	task automatic close_out();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#100000;
		bad_count++;
		close_out();
	end
	initial begin
		repeat (3) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		bus(1'b0, lalc_pkg::OFS_STATUS, 32'h0);
		bus(1'b0, 12'h040, 32'h0);
		bus(1'b1, lalc_pkg::OFS_IRQ_EN, 32'hF);
		xen = 4'hF;
		bus(1'b0, lalc_pkg::OFS_IRQ_EN, 32'hF);
		$display("test reset done");
		repeat (6) begin
			s = $random(seed);
			settle(2'h0, {1'b0, s[2:0]}, 12);
			rdflag();
		end
		bus(1'b1, lalc_pkg::OFS_IRQ_EN, 32'h0);
		xen = 4'h0;
		settle(2'h0, {1'b0, ~xst[2:0]}, 12);
		bus(1'b1, lalc_pkg::OFS_IRQ_CLR, 32'hF);
		xflag = 4'h0;
		rdflag();
		bus(1'b1, lalc_pkg::OFS_IRQ_EN, 32'hF);
		xen = 4'hF;
		$display("test live done");
		bus(1'b1, lalc_pkg::OFS_CTRL, 32'h1);
		settle(2'h1, {1'b0, xst[2:0]}, 120);
		settle(2'h1, {1'b1, xst[2:0]}, 600);
		settle(2'h0, {1'b0, xst[2:0]}, 60);
		bus(1'b1, lalc_pkg::OFS_CTRL, 32'h2);
		settle(2'h2, {1'b1, xst[2:0]}, 700);
		$display("test manual done");
		bus(1'b1, lalc_pkg::OFS_CTRL, 32'h3);
		xauto = 1'b1;
		settle(2'h2, {1'b0, xst[2:0]}, 700);
		settle(2'h1, {1'b1, xst[2:0]}, 700);
		settle(2'h0, {1'b1, xst[2:0]}, 700);
		settle(2'h2, {1'b0, xst[2:0]}, 700);
		rdflag();
		$display("test auto done");
		close_out();
	end
endmodule // tb
bind lalc_top lalc_checker chk_u (.*);
`default_nettype wire

/* rtl/lalc_code_watch.sv */
`timescale 1ns/10ps
`default_nettype none
// Detects a repeating code in the data stream and times its persistence
module lalc_code_watch #(
	parameter int LEN = 5,
	parameter logic [4:0] CODE = 5'h01,
	parameter logic [39:0] HOLD = 40'h0000000001
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic bit_valid_i,
	input wire logic bit_i,
	output logic present_o,
	output logic held_o
);
	logic [4:0] shift_reg;
	logic [4:0] shift_next;
	logic [2:0] fill_reg;
	logic [2:0] fill_next;
	logic [39:0] cnt_reg;
	logic [39:0] cnt_next;
	logic match_reg;
	logic match_next;
	logic [4:0] mask;
	logic [2:0] target;

	// Any phase of the repeating code is accepted, so no bit alignment is needed
	function automatic logic is_rotation(input logic [4:0] w);
		logic hit;
		logic [4:0] m;
		logic [4:0] r;
		m = 5'((6'h01 << LEN) - 6'h01);
		r = CODE & m;
		hit = 1'b0;
		for (int i = 0; i < LEN; i++) begin
			hit = hit | (w == r);
			r = ((r << 1) | (r >> (LEN - 1))) & m;
		end
		return hit;
	endfunction

	always_comb begin
		mask = 5'(( 6'h01 << LEN) - 6'h01);
		target = 3'(LEN);
		shift_next = shift_reg;
		fill_next = fill_reg;
		match_next = match_reg;
		if (bit_valid_i) begin
			shift_next = {shift_reg[3:0], bit_i};
			// Rotation check of the last LEN bits once every LEN bits; in between, each bit must equal the one LEN bits earlier
			if (fill_reg == target - 3'h1) begin
				fill_next = 3'h0;
				match_next = is_rotation(shift_next & mask);
			end else begin
				fill_next = fill_reg + 3'h1;
				if (match_reg && (bit_i != shift_reg[LEN-1])) begin
					match_next = 1'b0;
				end
			end
		end
		// Count restarts whenever the code breaks
		if (!match_reg) begin
			cnt_next = 40'h0;
		end else if (cnt_reg < HOLD) begin
			cnt_next = cnt_reg + 40'h1;
		end else begin
			cnt_next = cnt_reg;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_reg <= 5'h00;
			fill_reg <= 3'h0;
			cnt_reg <= 40'h0;
			match_reg <= 1'b0;
		end else begin
			shift_reg <= shift_next;
			fill_reg <= fill_next;
			cnt_reg <= cnt_next;
			match_reg <= match_next;
		end
	end

	assign present_o = match_reg;
	assign held_o = match_reg && (cnt_reg >= HOLD);
endmodule // lalc_code_watch
`default_nettype wire

/* rtl/lalc_pkg.sv */
package lalc_pkg;

	localparam int DATA_W = 32;
	localparam int ADDR_W = 12;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_IRQ_FLAG = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 12'h00C;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h010;

	// Bit positions shared by status, flag, clear and enable registers
	localparam int BIT_PATTERN = 0;
	localparam int BIT_RX_LOST = 1;
	localparam int BIT_ALL_ONES = 2;
	localparam int BIT_LOOP = 3;
	localparam int NUM_COND = 4;

	// Control register fields
	localparam int BIT_MODE_LO = 0;
	localparam int BIT_MODE_HI = 1;
	localparam int BIT_LOOPBACK = 2;

	localparam logic [3:0] COND_RESET = 4'h0;
	localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

	// Loop codes: five-bit loop-up and three-bit loop-down repeating patterns
	localparam logic [4:0] LOOP_UP_CODE = 5'h01;
	localparam logic [2:0] LOOP_DOWN_CODE = 3'h1;
	localparam int LOOP_UP_LEN = 5;
	localparam int LOOP_DOWN_LEN = 3;

	// Persistence time
	localparam int CLK_MHZ = 125;
	localparam longint HOLD_SEC = 5;
	localparam longint HOLD_CYCLES = HOLD_SEC * 64'd1000000 * CLK_MHZ + 1;
	localparam int HOLD_W = 40;

	typedef enum logic [1:0] {
		LALC_IDLE = 2'b00,
		LALC_WATCH_UP = 2'b01,
		LALC_LOOPED = 2'b11
	} lalc_auto_type;

	typedef struct packed {
		logic loop_code_seen;
		logic all_ones_alarm;
		logic rx_signal_lost;
		logic test_pattern_locked;
	} lalc_cond_type;

endpackage

/* rtl/lalc_top.sv */
// How it works
// - one select bit is manual, both automatic
// - manual: set after code persists five seconds
// - manual: hold while code present, clear otherwise
// - manual: interrupt on every loop bit change
// - entering automatic clears bit, watches loop-up
// - auto loop-up held: set, loopback, watch down
// - auto: bit stays set during loopback
// - auto loop-down held: drop loopback, clear, interrupt
// - all-ones bit follows live detector
// - all-ones change raises enabled interrupt
// - signal-lost bit follows live input
// - signal-lost change raises enabled interrupt
// - pattern-lock bit follows live detector
// - pattern-lock change raises enabled interrupt
// - loop interrupt only while its enable set
// - change latches flag, software clears it
`timescale 1ns/10ps
`default_nettype none
module lalc_top #(
	parameter logic [39:0] HOLD_COUNT = 40'(lalc_pkg::HOLD_CYCLES)
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [lalc_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [lalc_pkg::DATA_W-1:0] pwdata_i,
	output logic [lalc_pkg::DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic rx_bit_valid_i,
	input wire logic rx_data_i,
	input wire logic all_ones_alarm_i,
	input wire logic rx_signal_lost_i,
	input wire logic test_pattern_locked_i,
	output logic remote_loopback_o,
	output logic irq_o
);
	// Positions of the pin inputs inside the synchroniser words
	localparam int SYNC_LOCK = 0;
	localparam int SYNC_LOST = 1;
	localparam int SYNC_ONES = 2;
	localparam int SYNC_DATA = 3;
	localparam int SYNC_VALID = 4;
	localparam int SYNC_W = 5;
	localparam logic [SYNC_W-1:0] SYNC_RESET = 5'h00;
	localparam logic [1:0] MODE_RESET = 2'h0;

	// Two-flop synchronisers for pin inputs
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic [SYNC_W-1:0] sync_in;
	logic bit_valid_s;
	logic bit_s;
	lalc_pkg::lalc_cond_type live;

	always_comb begin
		sync_in = SYNC_RESET;
		sync_in[SYNC_LOCK] = test_pattern_locked_i;
		sync_in[SYNC_LOST] = rx_signal_lost_i;
		sync_in[SYNC_ONES] = all_ones_alarm_i;
		sync_in[SYNC_DATA] = rx_data_i;
		sync_in[SYNC_VALID] = rx_bit_valid_i;
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_reg <= SYNC_RESET;
			sync2_reg <= SYNC_RESET;
		end else begin
			sync1_reg <= sync_in;
			sync2_reg <= sync1_reg;
		end
	end

	// Valid is a level toggle per received bit, so its edge marks a bit
	logic valid_d_reg;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			valid_d_reg <= 1'b0;
		end else begin
			valid_d_reg <= sync2_reg[SYNC_VALID];
		end
	end
	assign bit_valid_s = sync2_reg[SYNC_VALID] ^ valid_d_reg;
	assign bit_s = sync2_reg[SYNC_DATA];

	// Loop code watchers
	logic up_present;
	logic up_held;
	logic down_present;
	logic down_held;

	lalc_code_watch #(
		.LEN(lalc_pkg::LOOP_UP_LEN),
		.CODE(lalc_pkg::LOOP_UP_CODE),
		.HOLD(HOLD_COUNT)
	) u_up (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.bit_valid_i(bit_valid_s),
		.bit_i(bit_s),
		.present_o(up_present),
		.held_o(up_held)
	);

	lalc_code_watch #(
		.LEN(lalc_pkg::LOOP_DOWN_LEN),
		.CODE({2'b00, lalc_pkg::LOOP_DOWN_CODE}),
		.HOLD(HOLD_COUNT)
	) u_down (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.bit_valid_i(bit_valid_s),
		.bit_i(bit_s),
		.present_o(down_present),
		.held_o(down_held)
	);

	// Registers
	logic [lalc_pkg::NUM_COND-1:0] irq_en_reg;
	logic [lalc_pkg::NUM_COND-1:0] irq_en_next;
	logic [1:0] mode_reg;
	logic [1:0] mode_next;
	logic [lalc_pkg::NUM_COND-1:0] flag_reg;
	logic [lalc_pkg::NUM_COND-1:0] flag_next;
	logic [lalc_pkg::NUM_COND-1:0] stat_reg;
	logic [lalc_pkg::NUM_COND-1:0] stat_next;
	logic [lalc_pkg::DATA_W-1:0] prdata_reg;
	logic [lalc_pkg::DATA_W-1:0] prdata_next;
	lalc_pkg::lalc_auto_type auto_reg;
	lalc_pkg::lalc_auto_type auto_next;
	logic loopback_reg;
	logic loopback_next;
	logic loop_manual_reg;
	logic loop_manual_next;

	logic wr_en;
	logic rd_en;
	logic wr_irq_en;
	logic wr_irq_clr;
	logic wr_ctrl;
	logic rd_flag;
	logic code_held;
	logic code_present;
	logic manual_mode;
	logic auto_mode;
	logic [lalc_pkg::NUM_COND-1:0] stat_live;
	logic [lalc_pkg::NUM_COND-1:0] change;
	logic [lalc_pkg::NUM_COND-1:0] clr;

	function automatic logic addr_hit(input logic [lalc_pkg::ADDR_W-1:0] a,
		input logic [lalc_pkg::ADDR_W-1:0] ofs);
		addr_hit = (a == ofs);
	endfunction

	assign wr_en = psel_i && penable_i && pwrite_i;
	assign rd_en = psel_i && !penable_i && !pwrite_i;
	assign manual_mode = mode_reg[lalc_pkg::BIT_MODE_HI] ^ mode_reg[lalc_pkg::BIT_MODE_LO];
	assign auto_mode = mode_reg[lalc_pkg::BIT_MODE_HI] && mode_reg[lalc_pkg::BIT_MODE_LO];

	assign wr_irq_en = wr_en && addr_hit(paddr_i, lalc_pkg::OFS_IRQ_EN);
	assign wr_irq_clr = wr_en && addr_hit(paddr_i, lalc_pkg::OFS_IRQ_CLR);
	assign wr_ctrl = wr_en && addr_hit(paddr_i, lalc_pkg::OFS_CTRL);
	// Read side effect fires once, in the setup cycle, never again in access
	assign rd_flag = rd_en && addr_hit(paddr_i, lalc_pkg::OFS_IRQ_FLAG);
	// Either code counts in manual mode; the watchers run in every mode
	assign code_held = up_held || down_held;
	assign code_present = up_present || down_present;

	// Loop-code status logic
	always_comb begin
		auto_next = auto_reg;
		loopback_next = loopback_reg;
		loop_manual_next = 1'b0;
		if (auto_mode) begin
			unique case (auto_reg)
				lalc_pkg::LALC_IDLE: begin
					auto_next = lalc_pkg::LALC_WATCH_UP;
					loopback_next = 1'b0;
				end
				lalc_pkg::LALC_WATCH_UP: begin
					if (up_held) begin
						auto_next = lalc_pkg::LALC_LOOPED;
						loopback_next = 1'b1;
					end
				end
				lalc_pkg::LALC_LOOPED: begin
					if (down_held) begin
						auto_next = lalc_pkg::LALC_WATCH_UP;
						loopback_next = 1'b0;
					end
				end
				default: begin
					auto_next = lalc_pkg::LALC_IDLE;
				end
			endcase
		end else begin
			auto_next = lalc_pkg::LALC_IDLE;
			loopback_next = 1'b0;
			// Set once held, then stays only while either code persists
			if (manual_mode) begin
				loop_manual_next = code_held || (loop_manual_reg && code_present);
			end
		end
	end

	// Live levels gathered in one bundle before they meet the register layout
	always_comb begin
		live.test_pattern_locked = sync2_reg[SYNC_LOCK];
		live.rx_signal_lost = sync2_reg[SYNC_LOST];
		live.all_ones_alarm = sync2_reg[SYNC_ONES];
		// Auto: bit mirrors the looped state, so it shows loopback
		live.loop_code_seen = auto_mode ? (auto_next == lalc_pkg::LALC_LOOPED) : loop_manual_next;
	end

	function automatic logic [lalc_pkg::NUM_COND-1:0] cond_bits(input lalc_pkg::lalc_cond_type c);
		logic [lalc_pkg::NUM_COND-1:0] v;
		v = lalc_pkg::COND_RESET;
		v[lalc_pkg::BIT_PATTERN] = c.test_pattern_locked;
		v[lalc_pkg::BIT_RX_LOST] = c.rx_signal_lost;
		v[lalc_pkg::BIT_ALL_ONES] = c.all_ones_alarm;
		v[lalc_pkg::BIT_LOOP] = c.loop_code_seen;
		return v;
	endfunction

	always_comb begin
		stat_live = cond_bits(live);
		stat_next = stat_live;
		change = stat_reg ^ stat_next;
		clr = '0;
		if (rd_flag) begin
			clr = flag_reg;
		end
		if (wr_irq_clr) begin
			clr = clr | pwdata_i[lalc_pkg::NUM_COND-1:0];
		end
		// Set wins over clear so no change is lost
		flag_next = (flag_reg & ~clr) | change;
	end

	// Bus side: writes land in the access cycle
	always_comb begin
		irq_en_next = irq_en_reg;
		mode_next = mode_reg;
		if (wr_irq_en) begin
			irq_en_next = pwdata_i[lalc_pkg::NUM_COND-1:0];
		end
		if (wr_ctrl) begin
			mode_next = pwdata_i[lalc_pkg::BIT_MODE_HI:lalc_pkg::BIT_MODE_LO];
		end
	end

	// Read data is captured in the setup cycle and holds through access
	always_comb begin
		prdata_next = prdata_reg;
		if (rd_en) begin
			prdata_next = lalc_pkg::ZERO_WORD;
			unique case (paddr_i)
				lalc_pkg::OFS_STATUS: prdata_next[lalc_pkg::NUM_COND-1:0] = stat_reg;
				lalc_pkg::OFS_IRQ_EN: prdata_next[lalc_pkg::NUM_COND-1:0] = irq_en_reg;
				lalc_pkg::OFS_IRQ_FLAG: prdata_next[lalc_pkg::NUM_COND-1:0] = flag_reg;
				lalc_pkg::OFS_CTRL: begin
					prdata_next[lalc_pkg::BIT_MODE_HI:lalc_pkg::BIT_MODE_LO] = mode_reg;
					prdata_next[lalc_pkg::BIT_LOOPBACK] = loopback_reg;
				end
				default: prdata_next = lalc_pkg::ZERO_WORD;
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_en_reg <= lalc_pkg::COND_RESET;
			mode_reg <= MODE_RESET;
			flag_reg <= lalc_pkg::COND_RESET;
			stat_reg <= lalc_pkg::COND_RESET;
			prdata_reg <= lalc_pkg::ZERO_WORD;
			auto_reg <= lalc_pkg::LALC_IDLE;
			loopback_reg <= 1'b0;
			loop_manual_reg <= 1'b0;
		end else begin
			irq_en_reg <= irq_en_next;
			mode_reg <= mode_next;
			flag_reg <= flag_next;
			stat_reg <= stat_next;
			prdata_reg <= prdata_next;
			auto_reg <= auto_next;
			loopback_reg <= loopback_next;
			loop_manual_reg <= loop_manual_next;
		end
	end

	assign pready_o = 1'b1;
	assign pslverr_o = 1'b0;
	assign prdata_o = prdata_reg;
	assign remote_loopback_o = loopback_reg;
	// Enable masks only the output; flags still latch for polling
	assign irq_o = |(flag_reg & irq_en_reg);
endmodule // lalc_top
`default_nettype wire
